//--- clk_sup_pkg.sv
// Constants and types for the PLL clock-loss supervisor
package clk_sup_pkg;

    // Register indices on the plain port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_RESET_STATUS = 4'h2;
    localparam logic [3:0] ADDR_DIVIDERS = 4'h3;

    // Control register fields
    localparam int CTRL_LOC_EN = 0;
    localparam int CTRL_LOC_RE = 1;
    localparam int CTRL_LOL_RE = 2;
    localparam int CTRL_STOP_LO = 3;
    localparam int CTRL_ONE_TO_ONE = 5;
    localparam int CTRL_EXT_MODE = 6;
    localparam int CTRL_SYSTEM_CLOCK_OUT_EN = 7;
    localparam logic [7:0] CTRL_RESET = 8'h83;

    // Divider register fields and reset value
    localparam int DIV_MFD_LO = 0;
    localparam int DIV_RFD_LO = 4;
    localparam logic [7:0] DIV_RESET = 8'h00;

    // Multiplier field decode: factor = code + 2 capped to 2..9
    localparam logic [2:0] MULT_MIN = 3'h2;
    localparam logic [3:0] MULT_MAX = 4'h9;
    localparam logic [2:0] CP_THRESH_2X = 3'h2;
    localparam logic [2:0] CP_THRESH_4X = 3'h6;

    // Stop mode codes
    localparam logic [1:0] STOP_ALL_ON = 2'h0;
    localparam logic [1:0] STOP_PLL_ON = 2'h1;
    localparam logic [1:0] STOP_OSC_ON = 2'h2;

    // Charge pump currents
    localparam logic [1:0] CP_FIXED = 2'h0;
    localparam logic [1:0] CP_1X = 2'h1;
    localparam logic [1:0] CP_2X = 2'h2;
    localparam logic [1:0] CP_4X = 2'h3;

    // Feedback path selections
    localparam logic [1:0] FB_SYSTEM_CLOCK_OUT = 2'h0;
    localparam logic [1:0] FB_VCO_DIV2 = 2'h1;
    localparam logic [1:0] FB_MFD = 2'h2;

    // Clock modes
    typedef enum logic [2:0] {
        NORMAL_PLL_MODE = 3'b000,
        REFERENCE_FALLBACK_MODE = 3'b001,
        SELF_CLOCKED_MODE = 3'b010,
        EXTERNAL_CLOCK_MODE = 3'b011,
        STATIC_MODE = 3'b100,
        RESET_MODE = 3'b101
    } clk_mode_t;

endpackage : clk_sup_pkg

//--- pll_clock_loss_supervisor.sv
// Supervisor of PLL modes, stop handling, clock-loss reset and divider selection
`timescale 1ns/100ps
`default_nettype none

module pll_clock_loss_supervisor (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic ref_tick_i,
    input wire logic ref_ok_i,
    input wire logic fb_ok_i,
    input wire logic lock_i,
    input wire logic scm_ok_i,
    input wire logic ext_clk_seen_i,
    input wire logic ext_reset_req_i,
    input wire logic stop_req_i,
    input wire logic ref_fall_i,
    input wire logic fb_fall_i,
    output logic pll_run_o,
    output logic osc_run_o,
    output logic sys_reset_o,
    output logic [2:0] mode_o,
    output logic [3:0] mult_factor_o,
    output logic [3:0] reduce_div_o,
    output logic [1:0] fb_sel_o,
    output logic [1:0] cp_current_o,
    output logic pump_up_o,
    output logic pump_down_o
);

    // Whole block state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] div;
        logic [7:0] rdata;
        clk_sup_pkg::clk_mode_t mode;
        logic in_stop;
        logic lock_flag;
        logic loss_flag;
        logic saved_lock;
        logic saved_loss;
        logic lock_masked;
        logic loss_masked;
        logic loss_cause;
        logic sys_reset;
        logic pll_run;
        logic osc_run;
        logic [3:0] mult;
        logic [3:0] rdiv;
        logic [1:0] fb_sel;
        logic [1:0] cp;
        logic up;
        logic down;
    } state_t;

    state_t q;
    state_t next_q;

    // Charge pump current from the divider code
    function automatic logic [1:0] cp_select(input logic [2:0] feedback_multiplier_divider, input logic one_to_one);
        if (one_to_one) begin
            cp_select = clk_sup_pkg::CP_FIXED;
        end else if (feedback_multiplier_divider < clk_sup_pkg::CP_THRESH_2X) begin
            cp_select = clk_sup_pkg::CP_1X;
        end else if (feedback_multiplier_divider < clk_sup_pkg::CP_THRESH_4X) begin
            cp_select = clk_sup_pkg::CP_2X;
        end else begin
            cp_select = clk_sup_pkg::CP_4X;
        end
    endfunction : cp_select

    // Next-state logic
    always_comb begin
        logic [1:0] stop_sel;
        logic one_to_one;
        logic ext_mode;
        logic loss_ev;
        logic [3:0] factor;
        stop_sel = 2'h0;
        one_to_one = 1'b0;
        ext_mode = 1'b0;
        loss_ev = 1'b0;
        factor = 4'h0;
        next_q = q;
        stop_sel = q.ctrl[clk_sup_pkg::CTRL_STOP_LO +: 2];
        one_to_one = q.ctrl[clk_sup_pkg::CTRL_ONE_TO_ONE];
        ext_mode = q.ctrl[clk_sup_pkg::CTRL_EXT_MODE];
        loss_ev = !ref_ok_i || !fb_ok_i;

        // Register writes and reads
        if (wr_i) begin
            case (addr_i)
                clk_sup_pkg::ADDR_CTRL: next_q.ctrl = wdata_i;
                clk_sup_pkg::ADDR_DIVIDERS: next_q.div = wdata_i;
                default: ;
            endcase
        end
        next_q.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                clk_sup_pkg::ADDR_CTRL: next_q.rdata = q.ctrl;
                clk_sup_pkg::ADDR_STATUS: next_q.rdata = {q.mode, 2'b00, q.in_stop,
                    q.loss_flag, q.lock_flag};
                clk_sup_pkg::ADDR_RESET_STATUS: next_q.rdata = {7'h00, q.loss_cause};
                clk_sup_pkg::ADDR_DIVIDERS: next_q.rdata = q.div;
                default: next_q.rdata = 8'h00;
            endcase
        end

        // Stop entry saves flags, wakeup restores them
        next_q.in_stop = stop_req_i;
        if (stop_req_i && !q.in_stop) begin
            next_q.saved_lock = q.lock_flag;
            next_q.saved_loss = q.loss_flag;
        end
        // wakeup shows 0 / 1 until lock and clock return
        if (!stop_req_i && q.in_stop) begin
            next_q.lock_masked = 1'b1;
            next_q.loss_masked = 1'b1;
        end
        next_q.lock_flag = (q.lock_masked && !lock_i) ? 1'b0 : q.saved_lock | lock_i;
        if (q.lock_masked && lock_i) begin
            next_q.lock_masked = 1'b0;
            next_q.lock_flag = q.saved_lock;
        end
        if (q.loss_masked) begin
            next_q.loss_flag = 1'b1;
            if (ref_ok_i) begin
                next_q.loss_masked = 1'b0;
                next_q.loss_flag = q.saved_loss;
            end
        end

        next_q.pll_run = !stop_req_i || stop_sel == clk_sup_pkg::STOP_ALL_ON
            || stop_sel == clk_sup_pkg::STOP_PLL_ON;
        next_q.osc_run = !stop_req_i || stop_sel != 2'h3 || one_to_one;

        // mode evaluated once per reference cycle, and every cycle while the reference is lost
        if (ref_tick_i || !ref_ok_i) begin
            case (q.mode)
                clk_sup_pkg::NORMAL_PLL_MODE: begin
                    if (ext_mode) begin
                        next_q.mode = clk_sup_pkg::EXTERNAL_CLOCK_MODE;
                    end else if (loss_ev && q.ctrl[clk_sup_pkg::CTRL_LOC_RE]) begin
                        next_q.mode = clk_sup_pkg::RESET_MODE;
                        next_q.loss_cause = 1'b1;
                    end else if (!lock_i && q.ctrl[clk_sup_pkg::CTRL_LOL_RE]) begin
                        next_q.mode = clk_sup_pkg::RESET_MODE;
                    end else if (loss_ev && !q.ctrl[clk_sup_pkg::CTRL_LOC_EN]) begin
                        next_q.mode = clk_sup_pkg::STATIC_MODE;
                    end else if (!ref_ok_i) begin
                        next_q.mode = clk_sup_pkg::SELF_CLOCKED_MODE;
                        next_q.loss_flag = 1'b1;
                    end else if (!fb_ok_i || !lock_i) begin
                        next_q.mode = clk_sup_pkg::REFERENCE_FALLBACK_MODE;
                        next_q.loss_flag = !fb_ok_i;
                    end else if (ext_reset_req_i && scm_ok_i) begin
                        next_q.mode = clk_sup_pkg::RESET_MODE;
                    end
                end
                clk_sup_pkg::REFERENCE_FALLBACK_MODE: begin
                    if (ext_reset_req_i && scm_ok_i) begin
                        next_q.mode = clk_sup_pkg::RESET_MODE;
                    end
                end
                clk_sup_pkg::SELF_CLOCKED_MODE: begin
                    if (!scm_ok_i) begin
                        next_q.mode = clk_sup_pkg::STATIC_MODE;
                    end else if (ext_reset_req_i) begin
                        next_q.mode = clk_sup_pkg::RESET_MODE;
                    end
                end
                clk_sup_pkg::EXTERNAL_CLOCK_MODE: begin
                    // no loss reset; reset seen only with a clock
                    if (!ext_mode) begin
                        next_q.mode = clk_sup_pkg::NORMAL_PLL_MODE;
                    end else if (ext_reset_req_i && ext_clk_seen_i) begin
                        next_q.mode = clk_sup_pkg::RESET_MODE;
                    end
                end
                clk_sup_pkg::RESET_MODE: begin
                    if (!scm_ok_i && !ref_ok_i) begin
                        next_q.mode = clk_sup_pkg::STATIC_MODE;
                    end else if (ref_ok_i && lock_i && !ext_reset_req_i) begin
                        next_q.mode = clk_sup_pkg::NORMAL_PLL_MODE;
                    end
                end
                clk_sup_pkg::STATIC_MODE: begin
                    if (ref_ok_i && scm_ok_i) begin
                        next_q.mode = clk_sup_pkg::RESET_MODE;
                    end
                end
                default: next_q.mode = clk_sup_pkg::RESET_MODE;
            endcase
        end
        next_q.sys_reset = next_q.mode == clk_sup_pkg::RESET_MODE;
        // Any system reset clears the sticky loss flag; the cause bit survives
        if (next_q.sys_reset) begin
            next_q.loss_flag = 1'b0;
        end

        factor = {1'b0, q.div[clk_sup_pkg::DIV_MFD_LO +: 3]} + {1'b0, clk_sup_pkg::MULT_MIN};
        if (factor > clk_sup_pkg::MULT_MAX) begin
            factor = clk_sup_pkg::MULT_MAX;
        end
        next_q.mult = one_to_one ? 4'h1 : factor;
        next_q.rdiv = q.div[clk_sup_pkg::DIV_RFD_LO +: 4];

        if (!one_to_one) begin
            next_q.fb_sel = clk_sup_pkg::FB_MFD;
        end else if (q.ctrl[clk_sup_pkg::CTRL_SYSTEM_CLOCK_OUT_EN]) begin
            next_q.fb_sel = clk_sup_pkg::FB_SYSTEM_CLOCK_OUT;
        end else begin
            next_q.fb_sel = clk_sup_pkg::FB_VCO_DIV2;
        end
        next_q.cp = cp_select(q.div[clk_sup_pkg::DIV_MFD_LO +: 3], one_to_one);

        // falling-edge comparison pulses
        // Dual latch: first edge opens its pulse, the other edge closes it
        next_q.up = (q.up || (ref_fall_i && !q.down)) && !fb_fall_i;
        next_q.down = (q.down || (fb_fall_i && !q.up)) && !ref_fall_i;
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.ctrl <= clk_sup_pkg::CTRL_RESET;
            q.div <= clk_sup_pkg::DIV_RESET;
            q.mode <= clk_sup_pkg::RESET_MODE;
            q.sys_reset <= 1'b1;
            q.loss_cause <= q.loss_cause;
            q.pll_run <= 1'b1;
            q.osc_run <= 1'b1;
            q.mult <= 4'h2;
            q.fb_sel <= clk_sup_pkg::FB_MFD;
            q.cp <= clk_sup_pkg::CP_1X;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_o = q.rdata;
    assign pll_run_o = q.pll_run;
    assign osc_run_o = q.osc_run;
    assign sys_reset_o = q.sys_reset;
    assign mode_o = q.mode;
    assign mult_factor_o = q.mult;
    assign reduce_div_o = q.rdiv;
    assign fb_sel_o = q.fb_sel;
    assign cp_current_o = q.cp;
    assign pump_up_o = q.up;
    assign pump_down_o = q.down;

endmodule : pll_clock_loss_supervisor
`default_nettype wire

//--- pll_clock_loss_supervisor_chk.sv
// Port assertions for the clock-loss supervisor
`timescale 1ns/100ps
`default_nettype none
module pll_clock_loss_supervisor_chk (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic ref_ok_i,
    input wire logic fb_ok_i,
    input wire logic lock_i,
    input wire logic ext_clk_seen_i,
    input wire logic stop_req_i,
    input wire logic pll_run_o,
    input wire logic osc_run_o,
    input wire logic sys_reset_o,
    input wire logic [2:0] mode_o,
    input wire logic [3:0] mult_factor_o,
    input wire logic [1:0] fb_sel_o,
    input wire logic [1:0] cp_current_o
);
    logic [7:0] ctrl;
    // Shadow of the control register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl <= clk_sup_pkg::CTRL_RESET;
        end else if (wr_i && addr_i == clk_sup_pkg::ADDR_CTRL) begin
            ctrl <= wdata_i;
        end
    end
    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Settled stop with a given code, normal crystal mode
    sequence in_stop(logic [1:0] c);
        (stop_req_i && ctrl[4:3] == c && ctrl[6:5] == 2'b00) [*3];
    endsequence
    sequence normal_run;
        mode_o == clk_sup_pkg::NORMAL_PLL_MODE && !stop_req_i;
    endsequence
    a_stop_pll_off: assert property (
        in_stop(2'h2) |-> !pll_run_o && osc_run_o) else $error("stop code 2 enables wrong");
    a_stop_all_off: assert property (
        in_stop(2'h3) |-> !pll_run_o && !osc_run_o) else $error("stop code 3 enables wrong");
    a_stop_all_on: assert property (
        in_stop(2'h1) |-> pll_run_o && osc_run_o) else $error("stop code 1 enables wrong");
    a_bypass_one: assert property (
        fb_sel_o != clk_sup_pkg::FB_MFD |-> mult_factor_o == 4'h1
        && cp_current_o == clk_sup_pkg::CP_FIXED) else $error("one to one bypass wrong");
    a_cp_ladder: assert property (
        fb_sel_o == clk_sup_pkg::FB_MFD |-> mult_factor_o inside {[2:9]} && cp_current_o ==
        (mult_factor_o < 4'h4 ? clk_sup_pkg::CP_1X : mult_factor_o < 4'h8 ? clk_sup_pkg::CP_2X
        : clk_sup_pkg::CP_4X)) else $error("charge pump current wrong");
    a_ref_to_scm: assert property (
        normal_run ##0 (!ref_ok_i && ctrl[2:0] == 3'b001 && !ctrl[6]) |-> ##[1:8]
        mode_o == clk_sup_pkg::SELF_CLOCKED_MODE) else $error("no self-clocked entry");
    a_fb_to_ref: assert property (
        normal_run ##0 (ref_ok_i && !fb_ok_i && ctrl[2:0] == 3'b001 && !ctrl[6]) |-> ##[1:12]
        mode_o == clk_sup_pkg::REFERENCE_FALLBACK_MODE) else $error("no fallback entry");
    a_loss_reset: assert property (
        normal_run ##0 (!ref_ok_i && ctrl[1] && !ctrl[6]) |-> ##[1:8] sys_reset_o)
        else $error("no reset on clock loss");
    a_ext_quiet: assert property (
        mode_o == clk_sup_pkg::EXTERNAL_CLOCK_MODE && !ext_clk_seen_i && !sys_reset_o
        |=> !sys_reset_o) else $error("reset in external mode");
    a_exit_lock: assert property (
        $fell(sys_reset_o) |-> $past(ref_ok_i) && $past(lock_i)) else $error("early reset exit");
endmodule : pll_clock_loss_supervisor_chk
bind pll_clock_loss_supervisor pll_clock_loss_supervisor_chk pll_clock_loss_supervisor_chk_i (.*);
`default_nettype wire

//--- pll_clock_loss_supervisor_tb.sv
// Self-checking bench for the clock-loss supervisor
`timescale 1ns/100ps
`default_nettype none
module pll_clock_loss_supervisor_tb;
    logic sys_clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, stop_req_i = 0;
    logic scm_ok_i = 1, ext_clk_seen_i = 0, ext_reset_req_i = 0;
    logic ref_lost = 0, fb_lost = 0, fb_lag = 0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o;
    logic ref_tick_i, ref_ok_i, fb_ok_i, lock_i, ref_fall_i, fb_fall_i;
    logic pll_run_o, osc_run_o, sys_reset_o, pump_up_o, pump_down_o;
    logic [2:0] mode_o;
    logic [3:0] mult_factor_o, reduce_div_o;
    logic [1:0] fb_sel_o, cp_current_o;
    int err_total = 0, comparisons = 0, ups = 0, downs = 0, u, d;
    always #12.5 sys_clk_i = !sys_clk_i;
    pll_clock_loss_supervisor pll_clock_loss_supervisor_i (.*);
    ref_source_model #(.PERIOD(4)) ref_source_model_i (.sys_clk_i(sys_clk_i),
        .ref_lost_i(ref_lost), .fb_lost_i(fb_lost), .fb_lag_i(fb_lag),
        .ref_tick_o(ref_tick_i), .ref_ok_o(ref_ok_i), .fb_ok_o(fb_ok_i), .lock_o(lock_i),
        .ref_fall_o(ref_fall_i), .fb_fall_o(fb_fall_i));
    // Pump pulse counters
    always @(posedge sys_clk_i) begin
        ups <= ups + 32'(pump_up_o);
        downs <= downs + 32'(pump_down_o);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o & m, e);
    endtask : rd
    function automatic logic [7:0] pick(input bit s);
        return s ? {7'h0, sys_reset_o} : {5'h0, mode_o};
    endfunction : pick
    // Bounded wait for mode or system reset
    task automatic wait_out(input bit s, input logic [7:0] e);
        int n = 0;
        while (pick(s) !== e && n < 60) begin
            cyc(1);
            n++;
        end
        chk(pick(s), e);
    endtask : wait_out
    task automatic do_reset();
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        cyc(3);
        rst_n_i <= 1'b1;
        wait_out(0, 8'h00);
    endtask : do_reset
    task automatic t_regs();
        rd(4'h0, 8'hFF, clk_sup_pkg::CTRL_RESET);
        wr(4'h1, 8'hFF);
        rd(4'hF, 8'hFF, 8'h00);
        rd(4'h1, 8'hE0, 8'h00);
        for (int m = 0; m < 8; m++) begin
            wr(4'h3, {4'(m + 1), 1'b0, 3'(m)});
            cyc(2);
            chk({4'h0, mult_factor_o}, (m > 6) ? 8'h09 : 8'(m + 2));
            chk({6'h0, cp_current_o}, (m < 2) ? 8'h01 : (m < 6) ? 8'h02 : 8'h03);
            chk({4'h0, reduce_div_o}, 8'(m + 1));
        end
        wr(4'h0, 8'hA3);
        cyc(2);
        chk({2'h0, fb_sel_o, mult_factor_o}, 8'h01);
        wr(4'h0, 8'h23);
        cyc(2);
        chk({2'h0, fb_sel_o, cp_current_o, 2'h0}, 8'h10);
        $display("registers and dividers done");
    endtask : t_regs
    task automatic t_stop();
        for (int c = 0; c < 5; c++) begin
            wr(4'h0, (c == 4) ? 8'hBB : 8'h83 | 8'(c << 3));
            stop_req_i <= 1'b1;
            cyc(5);
            chk({6'h0, pll_run_o, osc_run_o}, {6'h0, c < 2, c != 3});
            stop_req_i <= 1'b0;
            cyc(4);
        end
        wr(4'h0, 8'h83);
        fb_lag <= 1'b1;
        cyc(5);
        u = ups;
        d = downs;
        cyc(20);
        chk({6'h0, ups > u, downs > d}, 8'h02);
        fb_lag <= 1'b0;
        cyc(5);
        u = ups;
        d = downs;
        cyc(20);
        chk({6'h0, ups > u, downs > d}, 8'h01);
        $display("stop and pump done");
    endtask : t_stop
    task automatic t_loss();
        ref_lost <= 1'b1;
        wait_out(1, 8'h01);
        ref_lost <= 1'b0;
        wait_out(1, 8'h00);
        rd(4'h2, 8'h01, 8'h01);
        rd(4'h1, 8'h02, 8'h00);
        wr(4'h0, 8'h81);
        fb_lost <= 1'b1;
        wait_out(0, 8'h01);
        fb_lost <= 1'b0;
        do_reset();
        wr(4'h0, 8'h81);
        ref_lost <= 1'b1;
        wait_out(0, 8'h02);
        ref_lost <= 1'b0;
        do_reset();
        wr(4'h0, 8'h80);
        fb_lost <= 1'b1;
        wait_out(0, 8'h04);
        fb_lost <= 1'b0;
        do_reset();
        $display("clock loss done");
    endtask : t_loss
    task automatic t_ext();
        scm_ok_i <= 1'b0;
        ext_reset_req_i <= 1'b1;
        cyc(12);
        chk({7'h0, sys_reset_o}, 8'h00);
        scm_ok_i <= 1'b1;
        wait_out(1, 8'h01);
        ext_reset_req_i <= 1'b0;
        wait_out(1, 8'h00);
        wr(4'h0, 8'hC3);
        ref_lost <= 1'b1;
        cyc(12);
        chk({4'h0, sys_reset_o, mode_o}, 8'h03);
        ref_lost <= 1'b0;
        ext_reset_req_i <= 1'b1;
        cyc(12);
        chk({4'h0, sys_reset_o, mode_o}, 8'h03);
        ext_clk_seen_i <= 1'b1;
        wait_out(1, 8'h01);
        ext_reset_req_i <= 1'b0;
        ext_clk_seen_i <= 1'b0;
        do_reset();
        $display("external reset and mode done");
    endtask : t_ext
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        cyc(3);
        rst_n_i <= 1'b1;
        wait_out(0, 8'h00);
        t_regs();
        t_stop();
        t_loss();
        t_ext();
        end_sim();
    end
    // Watchdog
    initial begin
        cyc(5000);
        err_total++;
        end_sim();
    end
endmodule : pll_clock_loss_supervisor_tb
`default_nettype wire

//--- ref_source_model.sv
// Reference clock source with PLL feedback and lock status
`timescale 1ns/100ps
`default_nettype none
module ref_source_model #(parameter int PERIOD = 4) (
    input wire logic sys_clk_i,
    input wire logic ref_lost_i,
    input wire logic fb_lost_i,
    input wire logic fb_lag_i,
    output logic ref_tick_o,
    output logic ref_ok_o,
    output logic fb_ok_o,
    output logic lock_o,
    output logic ref_fall_o,
    output logic fb_fall_o
);
    int cnt = 0;
    // Free count of one reference period
    always @(posedge sys_clk_i) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
    // Edges vanish while the source is lost
    assign ref_ok_o = !ref_lost_i;
    assign fb_ok_o = !fb_lost_i;
    assign lock_o = ref_ok_o && fb_ok_o;
    assign ref_tick_o = ref_ok_o && cnt == 0;
    assign ref_fall_o = ref_tick_o;
    // Feedback edge just after or just before the reference edge
    assign fb_fall_o = lock_o && cnt == (fb_lag_i ? 1 : PERIOD - 1);
endmodule : ref_source_model
`default_nettype wire
